// *** gbsp_ctrl_model.sv ***
// External controller model driving or pulling the two general pins
`timescale 1ns/1ns
module gbsp_ctrl_model (
  input wire logic sys_clk,
  input wire logic [1:0] pinOut,
  input wire logic [1:0] pinOe,
  input wire logic [1:0] extEn,
  input wire logic [1:0] extVal,
  output logic [1:0] pinIn,
  output logic bootSeen
);
  logic lastQ = 1'b0;
  logic seenQ = 1'b0;
  // ========================================
  // Pin wire: weak pull-up when nobody drives
  assign pinIn = (pinOe & pinOut) | (~pinOe & (~extEn | extVal));
  assign bootSeen = seenQ;
  // Boot pin fall recorded in bootSeen
  always @(posedge sys_clk) begin
    if (lastQ && !pinIn[0]) begin
      seenQ <= 1'b1;
    end
    lastQ <= pinIn[0];
  end
endmodule

// *** gbsp_debounce.sv ***
// Input synchroniser and low-run filter for one general pin
`timescale 1ns/1ns
module gbsp_debounce #(
  parameter int RUN_W = 4
) (
  input wire logic sys_clk,
  input wire logic reset,
  input wire logic pinIn,
  input wire logic sampleTick,
  input wire logic useRun,
  input wire logic [RUN_W-1:0] runLen,
  output logic level
);
  import gbsp_pkg::*;

  logic sync1_q;
  logic sync2_q;
  logic [RUN_W-1:0] lowRun_q;

  // ============================================================
  // Two flops; only the second one is looked at
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      sync1_q <= 1'b1;
      sync2_q <= 1'b1;
    end else begin
      sync1_q <= pinIn;
      sync2_q <= sync1_q;
    end
  end

  // ============================================================
  // With useRun, low reported only after runLen consecutive low samples; without it level follows each sample
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      lowRun_q <= '0;
      level <= 1'b1;
    end else if (sampleTick) begin
      if (!useRun) begin
        level <= sync2_q;
      end else if (sync2_q) begin
        lowRun_q <= '0;
        level <= 1'b1;
      end else if (lowRun_q + 1'b1 >= runLen) begin
        level <= 1'b0;
      end else begin
        lowRun_q <= lowRun_q + 1'b1;
      end
    end
  end
endmodule

// *** gbsp_pkg.sv ***
// Constants, register map, timing figures and types for the boot status pin port
package gbsp_pkg;

  // ============================================================
  // Register map
  localparam logic [7:0] PIN_DIR_LEVEL_TICK_ADDR = 8'h0C;
  localparam int PIN_COUNT = 2;
  localparam int LEVEL_LSB = 0;
  localparam int DIR_LSB = 8;
  localparam int RUN_LSB = 12;
  localparam int RUN_W = 4;
  localparam int TICK_LSB = 16;
  localparam int TICK_W = 16;
  localparam logic [15:0] TICK_RESET = 16'h5820;
  localparam logic [3:0] RUN_RESET = 4'h3;

  // ============================================================
  // Timing
  localparam int CLK_HZ = 20_000_000;
  localparam int BUS_LOW_US = 1000;
  localparam int BUS_LOW_CYCLES = (BUS_LOW_US * (CLK_HZ / 1_000_000));
  localparam int LOAD_MS = 100;
  localparam int LOAD_CYCLES = LOAD_MS * (CLK_HZ / 1000);

  // ============================================================
  // Types
  typedef enum {
    BOOT_MASTER,
    BOOT_DEFAULT_INIT,
    BOOT_NORMAL
  } gbsp_boot_t;

  typedef struct packed {
    logic write;
    logic read;
    logic [7:0] addr;
    logic [31:0] wdata;
  } gbsp_req_t;

  typedef struct packed {
    logic memAbsent;
    logic memError;
    logic loadDone;
    logic slaveDownloadDone;
  } gbsp_load_t;

  typedef struct packed {
    logic serialOutActive;
    logic passThrough;
    logic slaveMode;
    logic memReadError;
  } gbsp_cfg_t;

endpackage

// *** gbsp_port.sv ***
// Two-pin general port with boot status role and pin_direction_level_tick register
`timescale 1ns/1ns
module gbsp_port #(
  parameter int LOAD_TIMEOUT = gbsp_pkg::LOAD_CYCLES,
  parameter int BUS_LOW_TIME = gbsp_pkg::BUS_LOW_CYCLES
) (
  input wire logic sys_clk,
  input wire logic reset,
  input wire gbsp_pkg::gbsp_req_t regReq,
  output logic [31:0] regRdata,
  input wire gbsp_pkg::gbsp_load_t loadEvt,
  input wire logic busSdaIn,
  input wire logic busSclIn,
  input wire logic [gbsp_pkg::PIN_COUNT-1:0] pinIn,
  output logic [gbsp_pkg::PIN_COUNT-1:0] pinOut,
  output logic [gbsp_pkg::PIN_COUNT-1:0] pinOe,
  output gbsp_pkg::gbsp_cfg_t cfgOut,
  output logic sampleTick
);
  import gbsp_pkg::*;

  initial begin
    if (LOAD_TIMEOUT < 1 || BUS_LOW_TIME < 1) begin
      $error("gbsp_port: timeouts must be at least one cycle");
    end
  end

  gbsp_boot_t boot_q;
  logic [PIN_COUNT-1:0] dir_q;
  logic [PIN_COUNT-1:0] outLevel_q;
  logic [PIN_COUNT-1:0] inLevel;
  logic [TICK_W-1:0] tickCount_q;
  logic [TICK_W-1:0] tickCnt_q;
  logic [RUN_W-1:0] runLen_q;
  logic strap_q;
  logic memErr_q;
  logic progDone_q;
  logic [31:0] loadCnt_q;
  logic [31:0] lowCnt_q;
  logic sda1_q;
  logic sda2_q;
  logic scl1_q;
  logic scl2_q;
  logic slaveMode;
  logic defaultStart;
  logic defaultDone;

  // Register field access
  function automatic logic isRegAddr(input logic [7:0] a);
    isRegAddr = (a == PIN_DIR_LEVEL_TICK_ADDR);
  endfunction

  // ============================================================
  // Bus line synchronisers for the held-low detector
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      sda1_q <= 1'b1;
      sda2_q <= 1'b1;
      scl1_q <= 1'b1;
      scl2_q <= 1'b1;
    end else begin
      sda1_q <= busSdaIn;
      sda2_q <= sda1_q;
      scl1_q <= busSclIn;
      scl2_q <= scl1_q;
    end
  end

  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      lowCnt_q <= '0;
    end else if (boot_q != BOOT_MASTER || sda2_q || scl2_q) begin
      lowCnt_q <= '0;
    end else if (lowCnt_q < 32'(BUS_LOW_TIME)) begin
      lowCnt_q <= lowCnt_q + 32'h1;
    end
  end

  // Fallback time-out; memory absent also reported as an event
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      loadCnt_q <= '0;
    end else if (boot_q != BOOT_NORMAL && loadCnt_q < 32'(LOAD_TIMEOUT)) begin
      loadCnt_q <= loadCnt_q + 32'h1;
    end
  end

  assign defaultStart = (boot_q == BOOT_MASTER) &&
    (loadEvt.memAbsent || loadEvt.memError || lowCnt_q >= 32'(BUS_LOW_TIME));
  // Status drive and init complete in one step here; slave mode is already on from defaultStart
  assign defaultDone = (boot_q == BOOT_DEFAULT_INIT) && (loadCnt_q >= 32'(LOAD_TIMEOUT));
  assign slaveMode = (boot_q != BOOT_MASTER);

  // ============================================================
  // Boot sequencer
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      boot_q <= BOOT_MASTER;
    end else begin
      case (boot_q)
        BOOT_MASTER: begin
          if (defaultStart) begin
            boot_q <= BOOT_DEFAULT_INIT;
          end else if (loadEvt.loadDone) begin
            boot_q <= BOOT_NORMAL;
          end
        end
        BOOT_DEFAULT_INIT: begin
          if (defaultDone) begin
            boot_q <= BOOT_NORMAL;
          end
        end
        default: begin
          boot_q <= BOOT_NORMAL;
        end
      endcase
    end
  end

  // Strap caught at start of default init, not under reset
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      strap_q <= 1'b1;
    end else if (defaultStart) begin
      strap_q <= inLevel[0];
    end
  end

  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      memErr_q <= 1'b0;
    end else if (loadEvt.memError) begin
      memErr_q <= 1'b1;
    end
  end

  // Direction writes to boot pin locked until programmed
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      progDone_q <= 1'b0;
    end else if ((boot_q == BOOT_MASTER && loadEvt.loadDone) || loadEvt.slaveDownloadDone) begin
      progDone_q <= 1'b1;
    end
  end

  // ============================================================
  // Register pin_direction_level_tick writes
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      dir_q <= '0;
      outLevel_q <= '0;
      tickCount_q <= TICK_RESET;
      runLen_q <= RUN_RESET;
    end else begin
      if (defaultDone) begin
        dir_q[0] <= 1'b1;
        outLevel_q[0] <= 1'b0;
      end
      if (regReq.write && isRegAddr(regReq.addr) && slaveMode) begin
        dir_q[PIN_COUNT-1:1] <= regReq.wdata[DIR_LSB+1 +: PIN_COUNT-1];
        outLevel_q <= regReq.wdata[LEVEL_LSB +: PIN_COUNT];
        tickCount_q <= regReq.wdata[TICK_LSB +: TICK_W];
        runLen_q <= regReq.wdata[RUN_LSB +: RUN_W];
        if (progDone_q) begin
          dir_q[0] <= regReq.wdata[DIR_LSB];
        end
      end
    end
  end

  // ============================================================
  // Sample tick divider, shared with diagnostics
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      tickCnt_q <= '0;
      sampleTick <= 1'b0;
    end else if (tickCnt_q + 16'h1 >= tickCount_q) begin
      tickCnt_q <= '0;
      sampleTick <= 1'b1;
    end else begin
      tickCnt_q <= tickCnt_q + 16'h1;
      sampleTick <= 1'b0;
    end
  end

  // Pins are level sensitive: one filter per pin
  generate
    for (genvar i = 0; i < PIN_COUNT; i++) begin : g_pin
      gbsp_debounce #(.RUN_W(RUN_W)) u_deb (
        .sys_clk(sys_clk),
        .reset(reset),
        .pinIn(pinIn[i]),
        .sampleTick(sampleTick),
        .useRun(!slaveMode),
        .runLen(runLen_q),
        .level(inLevel[i])
      );
    end
  endgenerate

  // ============================================================
  // Pin drive and read-back
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      pinOut <= '0;
      pinOe <= '0;
      regRdata <= '0;
    end else begin
      pinOut <= outLevel_q;
      pinOe <= dir_q;
      regRdata <= '0;
      if (regReq.read && isRegAddr(regReq.addr)) begin
        regRdata[LEVEL_LSB +: PIN_COUNT] <= inLevel & ~dir_q;
        regRdata[DIR_LSB +: PIN_COUNT] <= dir_q;
        regRdata[RUN_LSB +: RUN_W] <= runLen_q;
        regRdata[TICK_LSB +: TICK_W] <= tickCount_q;
      end
    end
  end

  // Audio configuration: pass-through and serial output picked by the latched strap and progDone_q
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      cfgOut <= '0;
    end else begin
      cfgOut.slaveMode <= slaveMode;
      cfgOut.memReadError <= memErr_q;
      cfgOut.passThrough <= (boot_q == BOOT_NORMAL) && !strap_q && !progDone_q;
      cfgOut.serialOutActive <= (boot_q == BOOT_NORMAL) && (!strap_q || progDone_q);
    end
  end
endmodule

// *** gbsp_port_asserts.sv ***
// Checker for the general pin port
`timescale 1ns/1ns
module gbsp_port_asserts
  import gbsp_pkg::*;
(
  input wire logic sys_clk,
  input wire logic reset,
  input wire gbsp_pkg::gbsp_req_t regReq,
  input wire logic [31:0] regRdata,
  input wire gbsp_pkg::gbsp_load_t loadEvt,
  input wire logic [gbsp_pkg::PIN_COUNT-1:0] pinOut,
  input wire logic [gbsp_pkg::PIN_COUNT-1:0] pinOe,
  input wire gbsp_pkg::gbsp_cfg_t cfgOut,
  input wire logic sampleTick
);
  logic hit;
  logic [15:0] tickQ;
  logic [15:0] gapQ;
  logic armQ;
  assign hit = regReq.addr == PIN_DIR_LEVEL_TICK_ADDR;
  default clocking @(posedge sys_clk); endclocking
  default disable iff (reset);
  // ========================================
  // Tick spacing, judged only on a full period after a write
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      tickQ <= TICK_RESET;
      gapQ <= 16'h0000;
      armQ <= 1'b0;
    end else begin
      gapQ <= sampleTick ? 16'h0000 : gapQ + 16'h0001;
      if (regReq.write && hit && cfgOut.slaveMode) begin
        tickQ <= regReq.wdata[31:16];
        armQ <= 1'b0;
      end else if (sampleTick) begin
        armQ <= 1'b1;
      end
    end
  end
  tick_gap_a: assert property (sampleTick && armQ |-> gapQ == tickQ - 16'h0001)
    else $error("tick spacing wrong");
  tick_pulse_a: assert property (sampleTick && tickQ > 16'h0001 |=> !sampleTick)
    else $error("tick not one cycle");
  reset_input_a: assert property ($past(reset) |-> pinOe == 2'h0)
    else $error("pin driven after reset");
  boot_low_a: assert property ($rose(pinOe[0]) && !$past(regReq.write, 2) |-> !pinOut[0])
    else $error("boot pin not driven low");
  pin_follow_a: assert property (regReq.write && hit && cfgOut.slaveMode |-> ##2
    pinOe[1] == $past(regReq.wdata[9], 2) && (!pinOe[1] || pinOut[1] == $past(regReq.wdata[1], 2)))
    else $error("pin does not follow write");
  out_zero_a: assert property (regReq.read && hit |=> (regRdata[1:0] & regRdata[9:8]) == 2'h0)
    else $error("output level bit not zero");
  mem_error_a: assert property (loadEvt.memError |-> ##[1:3] cfgOut.memReadError)
    else $error("memory error not recorded");
  pass_active_a: assert property (cfgOut.passThrough |-> cfgOut.serialOutActive)
    else $error("pass-through with silent outputs");
endmodule
bind gbsp_port gbsp_port_asserts u_chk (.sys_clk(sys_clk), .reset(reset), .regReq(regReq),
  .regRdata(regRdata), .loadEvt(loadEvt), .pinOut(pinOut), .pinOe(pinOe), .cfgOut(cfgOut),
  .sampleTick(sampleTick));

// *** testbench.sv ***
// Self-checking testbench for the general pin port
`timescale 1ns/1ns
module testbench;
  import gbsp_pkg::*;
  logic sys_clk = 1'b0;
  logic reset = 1'b1;
  gbsp_req_t regReq = '0;
  gbsp_load_t loadEvt = '0;
  logic [1:0] extEn = 2'h0;
  logic [1:0] extVal = 2'h0;
  logic [31:0] seed = 32'h0001236F;
  logic [31:0] regRdata, r, w;
  logic [1:0] pinIn, pinOut, pinOe;
  gbsp_cfg_t cfgOut;
  logic sampleTick, bootSeen;
  logic rdPend = 1'b0;
  logic [63:0] q[$];
  logic [63:0] note;
  int errors = 0;
  int checks = 0;
  gbsp_port #(.LOAD_TIMEOUT(200), .BUS_LOW_TIME(20)) dut (.sys_clk(sys_clk), .reset(reset),
    .regReq(regReq), .regRdata(regRdata), .loadEvt(loadEvt), .busSdaIn(1'b1), .busSclIn(1'b1),
    .pinIn(pinIn), .pinOut(pinOut), .pinOe(pinOe), .cfgOut(cfgOut), .sampleTick(sampleTick));
  gbsp_ctrl_model u_ctrl (.sys_clk(sys_clk), .pinOut(pinOut), .pinOe(pinOe), .extEn(extEn),
    .extVal(extVal), .pinIn(pinIn), .bootSeen(bootSeen));
  // ========================================
  // Tasks
  function automatic logic [31:0] xs();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction
  task automatic chk(input string n, input logic [31:0] ex, input logic [31:0] got);
    checks++;
    if (got !== ex) begin
      errors++;
      $display("mismatch %s expected %h seen %h", n, ex, got);
    end
  endtask
  task automatic req(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge sys_clk);
    #1 regReq = {wr, !wr, a, d};
    @(posedge sys_clk);
    #1 regReq = '0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] ex, input logic [31:0] m);
    q.push_back({ex & m, m});
    req(1'b0, a, 32'h0);
  endtask
  task automatic pulse(input gbsp_load_t v);
    @(posedge sys_clk);
    #1 loadEvt = v;
    @(posedge sys_clk);
    #1 loadEvt = '0;
  endtask
  task automatic close_out();
    if (errors == 0 && checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  // ========================================
  // Clock, monitor, watchdog
  initial forever #25 sys_clk = ~sys_clk;
  // Read data stands one cycle after the request edge; looked at mid-cycle
  always @(posedge sys_clk) begin
    rdPend <= regReq.read;
  end
  always @(negedge sys_clk) begin
    if (rdPend) begin
      note = q.pop_front();
      chk("regRdata", note[63:32], regRdata & note[31:0]);
    end
  end
  // Strap-low case waits three slow filter ticks
  initial begin
    #(50 * 80000);
    errors++;
    close_out();
  end
  // ========================================
  // Main sequence
  initial begin
    repeat (10) @(posedge sys_clk);
    #1 reset = 1'b0;
    pulse(4'b1000);
    for (int i = 0; i < 1000 && bootSeen !== 1'b1; i++) @(posedge sys_clk);
    #1 chk("bootDrive", 32'h1, {31'h0, pinOe[0] & ~pinOut[0]});
    chk("slaveMode", 32'h1, {31'h0, cfgOut.slaveMode});
    chk("serialOutActive", 32'h0, {31'h0, cfgOut.serialOutActive});
    chk("passThrough", 32'h0, {31'h0, cfgOut.passThrough});
    rd(8'h0C, 32'h58203000, 32'hFFFFF200);
    pulse(4'b0100);
    repeat (2) @(posedge sys_clk);
    #1 chk("memReadError", 32'h1, {31'h0, cfgOut.memReadError});
    pulse(4'b0001);
    for (int i = 0; i < 6; i++) begin
      r = xs();
      w = {16'h0010, 4'hF, 2'h0, (i == 0) ? 2'h3 : r[9:8], 6'h00, r[1:0]};
      extEn = r[17:16];
      extVal = r[25:24];
      req(1'b1, 8'h0C, w);
      repeat (2) @(posedge sys_clk);
      #1 chk("pinOe", {30'h0, w[9:8]}, {30'h0, pinOe});
      chk("pinOut", {30'h0, w[9:8] & w[1:0]}, {30'h0, pinOe & pinOut});
      // Long run length must not delay inputs in slave mode
      repeat (40) @(posedge sys_clk);
      rd(8'h0C, {w[31:8], 6'h00, ~w[9:8] & (~extEn | extVal)}, 32'hFFFFFFFF);
    end
    // Mid-run reset with the boot pin held low by the controller
    @(posedge sys_clk);
    #1 extEn = 2'h1;
    extVal = 2'h0;
    reset = 1'b1;
    repeat (2) @(posedge sys_clk);
    #1 reset = 1'b0;
    repeat (3 * int'(TICK_RESET) + 100) @(posedge sys_clk);
    pulse(4'b1000);
    repeat (10) @(posedge sys_clk);
    #1 chk("passThrough", 32'h1, {31'h0, cfgOut.passThrough});
    chk("serialOutActive", 32'h1, {31'h0, cfgOut.serialOutActive});
    chk("bootDrive", 32'h1, {31'h0, pinOe[0] & ~pinOut[0]});
    rd(8'h10, 32'h0, 32'hFFFFFFFF);
    repeat (2) @(posedge sys_clk);
    close_out();
  end
endmodule
